// File: core/rcd_dimmer.sv
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
module rcd_dimmer #(
    parameter int STEP_CYCLES = 200000,
    parameter int DEBOUNCE_CYCLES = 1001
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic encoderPhaseA,
    input wire logic encoderPhaseB,
    output rcd_pkg::rcd_pwm_t pwmOut,
    output logic powerStageEnableOut,
    output logic overflowFlag
);
    import rcd_pkg::*;

    function automatic logic [9:0] incIdx(input logic [9:0] v);
        incIdx = (v >= INDEX_LENGTH - 10'h001) ? INDEX_RESET : v + 10'h001;
    endfunction

    function automatic logic [9:0] decIdx(input logic [9:0] v);
        decIdx = (v == INDEX_RESET) ? INDEX_LENGTH - 10'h001 : v - 10'h001;
    endfunction

    // ==================================================
    // encoder synchroniser
    logic [1:0] encMeta_q, encSync_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            encMeta_q <= 2'h0;
            encSync_q <= 2'h0;
        end else begin
            encMeta_q <= {encoderPhaseB, encoderPhaseA};
            encSync_q <= encMeta_q;
        end
    end

    // ==================================================
    // duty tables, software loaded
    logic [15:0] dutyTab [3][TABLE_DEPTH];
    logic [7:0] tblAddr_q, tblAddr_d;
    logic [2:0] tabWe;
    logic [15:0] tabWdata;
    logic [7:0] lookAddr;
    rcd_duty_t lookDuty;

    generate
        for (genvar ch = 0; ch < 3; ch++) begin : g_tab
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    for (int i = 0; i < TABLE_DEPTH; i++) begin
                        dutyTab[ch][i] <= DUTY_RESET;
                    end
                end else if (tabWe[ch]) begin
                    dutyTab[ch][tblAddr_q] <= tabWdata;
                end
            end
        end
    endgenerate

    // ==================================================
    // timer, compare and outputs
    rcd_state_t state_q, state_d;
    logic [11:0] startCnt_q, startCnt_d;
    logic [2:0] divCnt_q, divCnt_d;
    logic [15:0] count_q, count_d;
    rcd_duty_t cmp_q, cmp_d;
    rcd_pwm_t pwm_q, pwm_d;
    logic enable_q, enable_d;
    logic ovf_q, ovf_d;
    logic tick, ovf, running;
    logic [9:0] colorIndex_q;

    assign running = (state_q == ST_RUN);
    assign tick = running && (divCnt_q == DIV_LAST);
    assign ovf = tick && (count_q == DUTY_MAX);
    // before the start the lookup is pinned to the first entry
    assign lookAddr = running ? colorIndex_q[9:2] : 8'h00;
    assign lookDuty.blue = dutyTab[0][lookAddr];
    assign lookDuty.green = dutyTab[1][lookAddr];
    assign lookDuty.red = dutyTab[2][lookAddr];

    always_comb begin
        state_d = state_q;
        startCnt_d = startCnt_q;
        divCnt_d = divCnt_q;
        count_d = count_q;
        cmp_d = cmp_q;
        pwm_d = pwm_q;
        enable_d = enable_q;
        ovf_d = 1'b0;
        case (state_q)
            ST_START: begin
                cmp_d = lookDuty;
                startCnt_d = startCnt_q + 12'h001;
                if (startCnt_q == STARTUP_LAST) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                divCnt_d = tick ? 3'h0 : divCnt_q + 3'h1;
                if (tick) begin
                    count_d = count_q + 16'h0001;
                end
                if (ovf) begin
                    // reloading mid-period could invert one cycle
                    cmp_d = lookDuty;
                    pwm_d = '0;
                    enable_d = 1'b1;
                    ovf_d = 1'b1;
                end else begin
                    if (count_q == cmp_q.blue) pwm_d.blue = 1'b1;
                    if (count_q == cmp_q.green) pwm_d.green = 1'b1;
                    if (count_q == cmp_q.red) pwm_d.red = 1'b1;
                end
            end
            default: state_d = ST_START;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_START;
            startCnt_q <= 12'h000;
            divCnt_q <= 3'h0;
            count_q <= COUNT_RESET;
            cmp_q <= {DUTY_RESET, DUTY_RESET, DUTY_RESET};
            pwm_q <= '0;
            enable_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            state_q <= state_d;
            startCnt_q <= startCnt_d;
            divCnt_q <= divCnt_d;
            count_q <= count_d;
            cmp_q <= cmp_d;
            pwm_q <= pwm_d;
            enable_q <= enable_d;
            ovf_q <= ovf_d;
        end
    end

    assign pwmOut = pwm_q;
    assign powerStageEnableOut = enable_q;
    // flag shows for one cycle: raised and cleared by the same handler
    assign overflowFlag = ovf_q;

    // ==================================================
    // index: auto stepping and encoder decoding
    logic [9:0] colorIndex_d;
    logic manual_q, manual_d;
    logic [1:0] startSample_q, startSample_d;
    logic [1:0] prevEnc_q, prevEnc_d;
    logic [31:0] stepCnt_q, stepCnt_d;
    logic [31:0] debCnt_q, debCnt_d;
    logic runStart;

    assign runStart = (state_q == ST_START) && (state_d == ST_RUN);

    always_comb begin
        colorIndex_d = colorIndex_q;
        manual_d = manual_q;
        startSample_d = startSample_q;
        prevEnc_d = prevEnc_q;
        stepCnt_d = stepCnt_q;
        debCnt_d = debCnt_q;
        if (runStart) begin
            startSample_d = encSync_q;
        end else if (running && !manual_q) begin
            if (encSync_q != startSample_q) begin
                manual_d = 1'b1;
                debCnt_d = 32'h0;
            end else if (stepCnt_q == 32'(STEP_CYCLES - 1)) begin
                stepCnt_d = 32'h0;
                colorIndex_d = incIdx(colorIndex_q);
            end else begin
                stepCnt_d = stepCnt_q + 32'h1;
            end
        end else if (manual_q) begin
            if (debCnt_q == 32'(DEBOUNCE_CYCLES - 1)) begin
                debCnt_d = 32'h0;
                if ((encSync_q == ENC_BOTH_LOW || encSync_q == ENC_A_HIGH)
                        && encSync_q != prevEnc_q) begin
                    prevEnc_d = encSync_q;
                    if (encSync_q == ENC_A_HIGH) begin
                        colorIndex_d = incIdx(colorIndex_q);
                    end else begin
                        colorIndex_d = decIdx(colorIndex_q);
                    end
                end
            end else begin
                debCnt_d = debCnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            colorIndex_q <= INDEX_RESET;
            manual_q <= 1'b0;
            startSample_q <= 2'h0;
            prevEnc_q <= ENC_PREV_RESET;
            stepCnt_q <= 32'h0;
            debCnt_q <= 32'h0;
        end else begin
            colorIndex_q <= colorIndex_d;
            manual_q <= manual_d;
            startSample_q <= startSample_d;
            prevEnc_q <= prevEnc_d;
            stepCnt_q <= stepCnt_d;
            debCnt_q <= debCnt_d;
        end
    end

    // ==================================================
    // avalon slave, one wait state on every access
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] wr16;
    logic wrTake;

    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign wrTake = avs_write && ack_q;
    assign wr16 = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
                   avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};
    // entries below the floor are lifted to keep a visible on time
    assign tabWdata = (wr16 < DUTY_MIN) ? DUTY_MIN : wr16;

    always_comb begin
        ack_d = (avs_read || avs_write) && !ack_q;
        rdata_d = rdata_q;
        tblAddr_d = tblAddr_q;
        tabWe = 3'b000;
        if (avs_read && !ack_q) begin
            rdata_d = 32'h0;
            if (avs_address == OFS_STATUS) begin
                rdata_d[9:0] = colorIndex_q;
                rdata_d[STAT_MANUAL_BIT] = manual_q;
                rdata_d[STAT_RUN_BIT] = running;
                rdata_d[STAT_ENABLE_BIT] = enable_q;
            end else if (avs_address == OFS_COUNT) begin
                rdata_d[15:0] = count_q;
            end else if (avs_address == OFS_TBL_ADDR) begin
                rdata_d[7:0] = tblAddr_q;
            end else if (avs_address == OFS_TBL_BLUE) begin
                rdata_d[15:0] = dutyTab[0][tblAddr_q];
            end else if (avs_address == OFS_TBL_GREEN) begin
                rdata_d[15:0] = dutyTab[1][tblAddr_q];
            end else if (avs_address == OFS_TBL_RED) begin
                rdata_d[15:0] = dutyTab[2][tblAddr_q];
            end
        end
        if (wrTake) begin
            if (avs_address == OFS_TBL_ADDR && avs_byteenable[0]) begin
                if (avs_writedata[7:0] < 8'(TABLE_DEPTH)) begin
                    tblAddr_d = avs_writedata[7:0];
                end
            end else if (avs_address == OFS_TBL_BLUE) begin
                tabWe[0] = 1'b1;
            end else if (avs_address == OFS_TBL_GREEN) begin
                tabWe[1] = 1'b1;
            end else if (avs_address == OFS_TBL_RED) begin
                tabWe[2] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
            tblAddr_q <= 8'h00;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            tblAddr_q <= tblAddr_d;
        end
    end

    assign avs_readdata = rdata_q;

    // ==================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_tick_gap;
        !tick [*4] ##1 tick;
    endsequence

    sequence s_overflow_done;
        pwmOut == '0 && powerStageEnableOut && overflowFlag
            && count_q == COUNT_RESET;
    endsequence

    a_index_range: assert property (
        colorIndex_q < INDEX_LENGTH)
        else $error("color index out of range");
    a_table_addr: assert property (
        ovf |=> cmp_q.red == $past(dutyTab[2][colorIndex_q[9:2]]))
        else $error("table address not index/4");
    a_duty_floor: assert property (
        tabWe != 3'b000 |-> tabWdata >= DUTY_MIN)
        else $error("table entry below floor");
    a_start_load: assert property (
        $rose(running) |-> colorIndex_q == INDEX_RESET
            && cmp_q.blue == dutyTab[0][0] && count_q == COUNT_RESET)
        else $error("first entries not loaded at start");
    a_overflow_wrap: assert property (
        ovf |=> s_overflow_done)
        else $error("overflow did not wrap and clear");
    a_tick_rate: assert property (
        tick |=> s_tick_gap)
        else $error("counter not at 8 MHz");
    a_set_match: assert property (
        running && !ovf && count_q == cmp_q.green |=> pwmOut.green)
        else $error("output not set on match");
    a_reload_only: assert property (
        running && !ovf |=> $stable(cmp_q))
        else $error("compare changed outside overflow");
    a_enable_hold: assert property (
        powerStageEnableOut |=> powerStageEnableOut)
        else $error("power stage enable dropped");
    a_start_delay: assert property (
        $rose(running) |-> $past(startCnt_q) == STARTUP_LAST)
        else $error("counter started early");
    a_manual_stick: assert property (
        manual_q |=> manual_q && $stable(startSample_q))
        else $error("manual mode left");
    a_auto_hold: assert property (
        running && !manual_q && colorIndex_q != colorIndex_d
            |-> encSync_q == startSample_q
            && stepCnt_q == 32'(STEP_CYCLES - 1))
        else $error("auto step at wrong time");
    a_manual_step: assert property (
        manual_q && colorIndex_q != colorIndex_d |->
            debCnt_q == 32'(DEBOUNCE_CYCLES - 1) && encSync_q != prevEnc_q
            && encSync_q[1] == 1'b0)
        else $error("manual step without valid change");
endmodule

// File: inc/rcd_pkg.sv
package rcd_pkg;
    // ==================================================
    // color table geometry
    localparam int TABLE_DEPTH = 252;
    localparam int INDEX_STEPS = 4;
    localparam logic [9:0] INDEX_LENGTH = 10'(TABLE_DEPTH * INDEX_STEPS);
    localparam logic [9:0] INDEX_RESET = 10'h000;
    localparam logic [15:0] DUTY_MIN = 16'h0064;
    localparam logic [15:0] DUTY_MAX = 16'hffff;
    localparam logic [15:0] DUTY_RESET = 16'hffff;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // ==================================================
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int CNT_HZ = 8_000_000;
    localparam int DIV_CYCLES = CLK_HZ / CNT_HZ;
    localparam logic [2:0] DIV_LAST = 3'(DIV_CYCLES - 1);
    localparam int STARTUP_CYCLES = 4000;
    localparam logic [11:0] STARTUP_LAST = 12'(STARTUP_CYCLES - 1);

    // ==================================================
    // encoder states, phase a in bit 0, phase b in bit 1
    localparam logic [1:0] ENC_PREV_RESET = 2'h1;
    localparam logic [1:0] ENC_BOTH_LOW = 2'h0;
    localparam logic [1:0] ENC_A_HIGH = 2'h1;

    // ==================================================
    // register byte offsets
    localparam logic [4:0] OFS_STATUS = 5'h00;
    localparam logic [4:0] OFS_COUNT = 5'h04;
    localparam logic [4:0] OFS_TBL_ADDR = 5'h08;
    localparam logic [4:0] OFS_TBL_BLUE = 5'h0c;
    localparam logic [4:0] OFS_TBL_GREEN = 5'h10;
    localparam logic [4:0] OFS_TBL_RED = 5'h14;
    localparam int STAT_MANUAL_BIT = 16;
    localparam int STAT_RUN_BIT = 17;
    localparam int STAT_ENABLE_BIT = 18;

    typedef struct packed {
        logic red;
        logic green;
        logic blue;
    } rcd_pwm_t;

    typedef struct packed {
        logic [15:0] red;
        logic [15:0] green;
        logic [15:0] blue;
    } rcd_duty_t;

    typedef enum logic [1:0] {
        ST_START = 2'b01,
        ST_RUN = 2'b10
    } rcd_state_t;
endpackage

// File: bench/rcd_led_model.sv
`timescale 1ns/100ps
module rcd_led_model (
    input wire logic clock,
    input rcd_pkg::rcd_pwm_t pwmOut,
    input wire logic powerStageEnableOut,
    output logic encoderPhaseA,
    output logic encoderPhaseB,
    output logic [2:0] ledLit
);
    import rcd_pkg::*;
    // ==================================================
    // power stages
    logic enableNet;
    // pulldown keeps the stages off while the line is not driven high
    assign enableNet = (powerStageEnableOut === 1'b1);
    // low dimming level means full current, high forces zero
    assign ledLit = enableNet ? ~pwmOut : 3'b000;
    // ==================================================
    // encoder, rests at a high, b low
    initial begin
        encoderPhaseA = 1'b1;
        encoderPhaseB = 1'b0;
    end
    task automatic turnTo(input logic [1:0] ba);
        @(posedge clock);
        encoderPhaseB <= ba[1];
        encoderPhaseA <= ba[0];
    endtask
endmodule

// File: bench/rcd_testbench.sv
`timescale 1ns/100ps
module testbench;
    import rcd_pkg::*;
    localparam int LIMIT = 500000;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] avsAddress = 5'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic encA;
    logic encB;
    rcd_pwm_t pwm;
    logic [2:0] pwmBits;
    logic enable;
    logic ovf;
    logic [2:0] ledLit;
    logic [31:0] rd;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int relCyc = 0;

    assign pwmBits = pwm;
    always #12.5 clock = ~clock;

    // short step and debounce counts keep the run small
    rcd_dimmer #(.STEP_CYCLES(20), .DEBOUNCE_CYCLES(4)) DUT (
        .clock(clock), .arst_n(arst_n), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWritedata), .avs_byteenable(4'hf),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
        .encoderPhaseA(encA), .encoderPhaseB(encB), .pwmOut(pwm),
        .powerStageEnableOut(enable), .overflowFlag(ovf)
    );
    rcd_led_model partner (
        .clock(clock), .pwmOut(pwm), .powerStageEnableOut(enable),
        .encoderPhaseA(encA), .encoderPhaseB(encB), .ledLit(ledLit)
    );

    // ==================================================
    // helpers
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic access(input logic wr, input logic [4:0] a,
                          input logic [31:0] d);
        int n;
        n = 0;
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= wr;
        avsRead <= ~wr;
        // only the cycle ceiling ends a wait that never answers
        do begin
            @(posedge clock);
            n++;
        end while (avsWaitrequest !== 1'b0);
        rd = avsReaddata;
        // one wait state on every access
        check("waitStates", 32'(n), 32'h2);
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge clock);
    endtask

    function automatic int greenOf(input int row);
        return 'h1000 + row * 'h40;
    endfunction

    // ==================================================
    // scenarios
    task automatic testReset();
        logic [15:0] wv [3] = '{16'd99, 16'd100, 16'hffff};
        logic [15:0] ev [3] = '{16'd100, 16'd100, 16'hffff};
        check("pwmReset", 32'(pwmBits), 32'h0);
        check("enableReset", 32'(enable), 32'h0);
        access(1'b0, OFS_STATUS, 32'h0);
        check("status", rd, 32'h0);
        access(1'b0, OFS_TBL_BLUE, 32'h0);
        check("tableReset", 32'(rd[15:0]), 32'hffff);
        access(1'b0, 5'h18, 32'h0);
        check("unmapped", rd, 32'h0);
        access(1'b1, OFS_COUNT, 32'h1234);
        access(1'b0, OFS_COUNT, 32'h0);
        check("countIdle", rd, 32'h0);
        access(1'b1, OFS_TBL_ADDR, 32'd252);
        access(1'b0, OFS_TBL_ADDR, 32'h0);
        check("addrLimit", rd, 32'h0);
        for (int k = 0; k < 3; k++) begin
            access(1'b1, OFS_TBL_BLUE, 32'(wv[k]));
            access(1'b0, OFS_TBL_BLUE, 32'h0);
            check("dutyClamp", 32'(rd[15:0]), 32'(ev[k]));
        end
    endtask

    task automatic testFill();
        for (int r = 0; r < TABLE_DEPTH; r++) begin
            access(1'b1, OFS_TBL_ADDR, 32'(r));
            access(1'b1, OFS_TBL_BLUE, 32'd50);
            access(1'b1, OFS_TBL_GREEN, 32'(greenOf(r)));
            access(1'b1, OFS_TBL_RED, 32'h2000);
        end
        access(1'b0, OFS_TBL_GREEN, 32'h0);
        check("greenLast", rd, 32'(greenOf(251)));
    endtask

    task automatic testStart();
        int n;
        int el;
        n = 0;
        rd = 32'h0;
        while (rd[STAT_RUN_BIT] !== 1'b1 && n < 2000) begin
            access(1'b0, OFS_STATUS, 32'h0);
            n++;
        end
        el = cyc - relCyc;
        check("startDelay", 32'(el >= STARTUP_CYCLES - 2 &&
              el <= STARTUP_CYCLES + 16), 32'h1);
    endtask

    task automatic testAutoWrap();
        int n;
        int d;
        logic [9:0] prev;
        logic [9:0] idx;
        logic wrapped;
        access(1'b0, OFS_STATUS, 32'h0);
        prev = rd[9:0];
        repeat (200) @(posedge clock);
        access(1'b0, OFS_STATUS, 32'h0);
        idx = rd[9:0];
        d = (int'(idx) + 1008 - int'(prev)) % 1008;
        check("stepRate", 32'(d >= 10 && d <= 11), 32'h1);
        wrapped = 1'b0;
        n = 0;
        prev = idx;
        while (!wrapped && n < 7000) begin
            access(1'b0, OFS_STATUS, 32'h0);
            idx = rd[9:0];
            n++;
            if (idx < prev) begin
                wrapped = 1'b1;
                check("wrapFrom", 32'(prev), 32'd1007);
                check("wrapTo", 32'(idx), 32'd0);
            end
            prev = idx;
        end
        check("autoMode", 32'({wrapped, rd[STAT_MANUAL_BIT]}), 32'h2);
    endtask

    task automatic testManual();
        logic [1:0] seq [6] = '{2'b11, 2'b10, 2'b00, 2'b01, 2'b11, 2'b01};
        int offs [6] = '{0, 0, 1007, 0, 0, 0};
        logic [9:0] base;
        partner.turnTo(seq[0]);
        repeat (20) @(posedge clock);
        access(1'b0, OFS_STATUS, 32'h0);
        base = rd[9:0];
        check("manualBit", 32'(rd[STAT_MANUAL_BIT]), 32'h1);
        repeat (100) @(posedge clock);
        access(1'b0, OFS_STATUS, 32'h0);
        check("autoStopped", 32'(rd[9:0]), 32'(base));
        for (int k = 1; k < 6; k++) begin
            partner.turnTo(seq[k]);
            repeat (20) @(posedge clock);
            access(1'b0, OFS_STATUS, 32'h0);
            check("manualIndex", 32'(rd[9:0]),
                  32'((int'(base) + offs[k]) % 1008));
        end
    endtask

    task automatic testOverflow();
        int t;
        int c1;
        int tr [3];
        int expc [3];
        logic [2:0] p1;
        logic [2:0] p2;
        access(1'b0, OFS_COUNT, 32'h0);
        c1 = int'(rd[15:0]);
        repeat (50) @(posedge clock);
        access(1'b0, OFS_COUNT, 32'h0);
        t = int'(rd[15:0]) - c1;
        check("countRate", 32'(t >= 10 && t <= 11), 32'h1);
        access(1'b0, OFS_STATUS, 32'h0);
        expc = '{100, greenOf(int'(rd[9:0]) / 4), 'h2000};
        // first entries still active: blue past 100, red not yet at 0x2000
        check("noEarlySet", 32'({pwmBits[2], pwmBits[0]}), 32'h1);
        t = 0;
        p1 = 3'b000;
        p2 = 3'b000;
        while (t < 340000) begin
            @(negedge clock);
            t++;
            if (ovf === 1'b1)
                break;
            p2 = p1;
            p1 = pwmBits;
        end
        check("setBeforeWrap", 32'(p2), 32'h7);
        check("clearAtWrap", 32'(pwmBits), 32'h0);
        check("enableAtWrap", 32'(enable), 32'h1);
        check("ledsLit", 32'(ledLit), 32'h7);
        t = 0;
        tr = '{0, 0, 0};
        while ((tr[0] == 0 || tr[1] == 0 || tr[2] == 0) && t < 120000) begin
            @(negedge clock);
            t++;
            if (t == 1)
                check("flagPulse", 32'(ovf), 32'h0);
            for (int k = 0; k < 3; k++)
                if (pwmBits[k] === 1'b1 && tr[k] == 0)
                    tr[k] = t;
        end
        for (int k = 0; k < 3; k++)
            check("riseTime", 32'(tr[k] >= expc[k] * 5 - 8 &&
                  tr[k] <= expc[k] * 5 + 8), 32'h1);
        check("ledsDark", 32'(ledLit), 32'h0);
        access(1'b0, OFS_STATUS, 32'h0);
        check("enableBit", 32'(rd[STAT_ENABLE_BIT]), 32'h1);
    endtask

    initial begin
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        relCyc = cyc;
        @(posedge clock);
        testReset();
        testFill();
        testStart();
        testAutoWrap();
        testManual();
        testOverflow();
        end_sim();
    end
endmodule
